// ==== rtl/pgc_config.sv ====
// Global configuration register with interrupt pin gate, access mode,
// priority select and detect/class event qualification.
// Assumes a decoded I2C access port on core_clk; result strobes are same-domain.
`timescale 1ns/1ns
`include "pgc_cfg.svh"
module pgc_config (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire pgc_pkg::pgc_access_t acc,
  output logic [7:0]               rdata,
  output logic                     addr_match,
  output logic                     wide_mode,
  input  wire logic [15:0]         irq_pending,
  input  wire logic [15:0]         irq_mask,
  output logic                     irq_n,
  output logic                     prio_3bit,
  output logic [7:0]               prio_reg_sel,
  input  wire pgc_pkg::pgc_result_t cls_in,
  input  wire pgc_pkg::pgc_result_t det_in,
  output logic [`PGC_NUM_CH-1:0]   class_event_flag,
  output logic [`PGC_NUM_CH-1:0]   detect_event_flag
);
  pgc_pkg::pgc_cfg_t        cfg_lo_reg;
  pgc_pkg::pgc_cfg_t        cfg_hi_reg;
  logic [`PGC_NUM_CH*`PGC_RES_W-1:0] cls_prev_reg;
  logic [`PGC_NUM_CH*`PGC_RES_W-1:0] det_prev_reg;
  logic                     cfg_hit;
  logic                     half_hi;

  // Result changed or every cycle counts, per channel
  function automatic logic [`PGC_NUM_CH-1:0] qualify(
    input logic [`PGC_NUM_CH-1:0]             done,
    input logic [`PGC_NUM_CH*`PGC_RES_W-1:0]  now,
    input logic [`PGC_NUM_CH*`PGC_RES_W-1:0]  prev,
    input logic                               chg_only);
    logic [`PGC_NUM_CH-1:0] q;
    q = '0;
    for (int i = 0; i < `PGC_NUM_CH; i++) begin
      q[i] = done[i] &&
             (!chg_only || now[i*`PGC_RES_W +: `PGC_RES_W] != prev[i*`PGC_RES_W +: `PGC_RES_W]);
    end
    return q;
  endfunction

  // Wide mode follows the channel 1-4 half only
  assign wide_mode  = cfg_lo_reg.wide_access_select;
  assign addr_match = wide_mode ? !acc.slave_addr_lsb : 1'b1;
  assign half_hi    = !wide_mode && acc.slave_addr_lsb;
  assign cfg_hit    = addr_match && acc.cmd == `PGC_CMD_CONFIG;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_lo_reg <= pgc_pkg::pgc_cfg_t'(`PGC_RESET_VALUE);
    end else if (acc.wr && cfg_hit && !half_hi) begin
      cfg_lo_reg <= pgc_pkg::pgc_cfg_t'(acc.wdata);
    end
  end

  // In wide mode a write reaches both halves so they stay coherent
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_hi_reg <= pgc_pkg::pgc_cfg_t'(`PGC_RESET_VALUE);
    end else if (acc.wr && cfg_hit && (half_hi || wide_mode)) begin
      cfg_hi_reg <= pgc_pkg::pgc_cfg_t'(acc.wdata);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (acc.rd && cfg_hit) begin
      rdata <= half_hi ? cfg_hi_reg : cfg_lo_reg;
    end
  end

  // Pin gate only; event state is untouched by the enable
  assign irq_n = !(cfg_lo_reg.irq_pin_global_enable && |(irq_pending & ~irq_mask));

  // Host must idle the shutdown input before raising this
  assign prio_3bit    = cfg_lo_reg.multilevel_priority_select;
  assign prio_reg_sel = prio_3bit ? `PGC_CMD_PRIO_3BIT_A : `PGC_CMD_PRIO_1BIT;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      class_event_flag  <= '0;
      detect_event_flag <= '0;
    end else begin
      class_event_flag  <= qualify(cls_in.done, cls_in.result, cls_prev_reg,
                                   cfg_lo_reg.class_change_only);
      detect_event_flag <= qualify(det_in.done, det_in.result, det_prev_reg,
                                   cfg_lo_reg.detect_change_only);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cls_prev_reg <= '0;
      det_prev_reg <= '0;
    end else begin
      for (int i = 0; i < `PGC_NUM_CH; i++) begin
        if (cls_in.done[i]) cls_prev_reg[i*`PGC_RES_W +: `PGC_RES_W] <=
                                cls_in.result[i*`PGC_RES_W +: `PGC_RES_W];
        if (det_in.done[i]) det_prev_reg[i*`PGC_RES_W +: `PGC_RES_W] <=
                                det_in.result[i*`PGC_RES_W +: `PGC_RES_W];
      end
    end
  end

  AST_IRQ_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    !cfg_lo_reg.irq_pin_global_enable |-> irq_n) else $error("irq active while disabled");
  AST_IRQ_ON: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_lo_reg.irq_pin_global_enable && |(irq_pending & ~irq_mask)) |-> !irq_n)
    else $error("unmasked irq not driven");
  AST_WIDE_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wide_mode && acc.slave_addr_lsb) |-> !addr_match) else $error("odd address in wide mode");
  AST_NARROW_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wide_mode |-> addr_match) else $error("half not answering");
  AST_PRIO: assert property (@(posedge core_clk) disable iff (!arst_n)
    prio_reg_sel == (cfg_lo_reg.multilevel_priority_select ? 8'h27 : 8'h15))
    else $error("wrong priority source");
  AST_CLS_ALL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!cfg_lo_reg.class_change_only && cls_in.done[0]) |=> class_event_flag[0])
    else $error("class event missed");
  AST_DET_ALL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!cfg_lo_reg.detect_change_only && det_in.done[0]) |=> detect_event_flag[0])
    else $error("detect event missed");
  AST_DET_SAME: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_lo_reg.detect_change_only && det_in.done[0] &&
     det_in.result[3:0] == det_prev_reg[3:0]) |=> !detect_event_flag[0])
    else $error("unchanged detect flagged");
  AST_CLS_SAME: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_lo_reg.class_change_only && cls_in.done[0] &&
     cls_in.result[3:0] == cls_prev_reg[3:0]) |=> !class_event_flag[0])
    else $error("unchanged class flagged");
  AST_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && cfg_hit && !half_hi) |=> cfg_lo_reg == $past(acc.wdata))
    else $error("write not stored");


  // Read path and the channel 5-8 copy
  AST_RD_LO: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.rd && cfg_hit && !half_hi)
    |=> rdata == $past(cfg_lo_reg))
    else $error("low half read wrong");

  AST_RD_HI: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.rd && cfg_hit && half_hi)
    |=> rdata == $past(cfg_hi_reg))
    else $error("high half read wrong");

  AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(acc.rd && cfg_hit)
    |=> rdata == $past(rdata))
    else $error("read data moved without read");

  AST_HI_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && cfg_hit && half_hi)
    |=> cfg_hi_reg == $past(acc.wdata))
    else $error("high half write not stored");

  AST_HI_ISOLATE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && cfg_hit && half_hi)
    |=> cfg_lo_reg == $past(cfg_lo_reg))
    else $error("high half write leaked");

  // A wide write must leave both copies equal, else a later narrow read disagrees
  AST_WIDE_BOTH: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && cfg_hit && wide_mode)
    |=> cfg_hi_reg == $past(acc.wdata))
    else $error("wide write missed high half");

  AST_WIDE_ODD_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && wide_mode && acc.slave_addr_lsb)
    |=> cfg_lo_reg == $past(cfg_lo_reg) && cfg_hi_reg == $past(cfg_hi_reg))
    else $error("odd address write taken in wide mode");

  AST_NO_WR_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(acc.wr && cfg_hit)
    |=> cfg_lo_reg == $past(cfg_lo_reg))
    else $error("config changed without write");

  AST_OTHER_CMD: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acc.wr && acc.cmd != `PGC_CMD_CONFIG)
    |=> cfg_lo_reg == $past(cfg_lo_reg) && cfg_hi_reg == $past(cfg_hi_reg))
    else $error("foreign command changed config");

  AST_IRQ_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(|(irq_pending & ~irq_mask))
    |-> irq_n)
    else $error("irq active with nothing pending");

  // Change detection against the stored previous result
  AST_CLS_CHG: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cls_in.done[0] && cls_in.result[3:0] != cls_prev_reg[3:0])
    |=> class_event_flag[0])
    else $error("changed class not flagged");

  AST_DET_CHG: assert property (@(posedge core_clk) disable iff (!arst_n)
    (det_in.done[0] && det_in.result[3:0] != det_prev_reg[3:0])
    |=> detect_event_flag[0])
    else $error("changed detect not flagged");

  AST_CLS_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !cls_in.done[0]
    |=> !class_event_flag[0])
    else $error("class flag without cycle");

  AST_DET_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !det_in.done[0]
    |=> !detect_event_flag[0])
    else $error("detect flag without cycle");

  COV_WIDE: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(wide_mode));
  COV_CLS_EVT: cover property (@(posedge core_clk) disable iff (!arst_n)
    cfg_lo_reg.class_change_only && class_event_flag[0]);
  COV_IRQ: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(irq_n));
  COV_PRIO: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(prio_3bit));
endmodule

// ==== shared/pgc_cfg.svh ====
// Constants for the global interrupt, access and priority configuration register.
// Assumes an I2C command decoder in front that delivers command code and data byte.
// Operation
// - With the global interrupt enable bit at 0 the interrupt pin never goes active.
// - With the global interrupt enable bit at 1 any unmasked interrupt bit drives the pin.
// - The global interrupt enable bit gates only the pin, never event latching.
// - With wide access set the device answers at one address with address bit zero, 16-bit.
// - With wide access clear the device acts as two 4-channel halves at two addresses, 8-bit; here all 8 channels and the pin follow the 1-4 half.
// - Wide access set in the channel 1-4 half alone enables 16-bit operation.
// - Multilevel priority at 1 uses registers 0x27/0x28, at 0 uses register 0x15.
// - With class change only at 1 a class event is flagged only when the class differs.
// - With class change only at 0 a class event is flagged on every classification.
// - With detect change only at 1 a detect event is flagged only when the result differs.
// - With detect change only at 0 a detect event is flagged on every detection.
// - The register sits at command code 17h as one read/write data byte.
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH
`define PGC_CMD_CONFIG      8'h17
`define PGC_CMD_PRIO_1BIT   8'h15
`define PGC_CMD_PRIO_3BIT_A 8'h27
`define PGC_CMD_PRIO_3BIT_B 8'h28
`define PGC_RESET_VALUE     8'h80
`define PGC_BIT_IRQ_EN      7
`define PGC_BIT_WIDE        5
`define PGC_BIT_MLPRIO      4
`define PGC_BIT_CLS_CHG     3
`define PGC_BIT_DET_CHG     2
`define PGC_NUM_CH          8
`define PGC_RES_W           4
`define PGC_IDLE_US         200
`define PGC_CLK_MHZ         100
`define PGC_IDLE_CYCLES     (`PGC_IDLE_US * `PGC_CLK_MHZ)
`endif

// ==== shared/pgc_pkg.sv ====
// Types for the global configuration register block.
// Assumes pgc_cfg.svh for all numeric constants.
`include "pgc_cfg.svh"
package pgc_pkg;
  typedef struct packed {
    logic       irq_pin_global_enable;
    logic       spare6;
    logic       wide_access_select;
    logic       multilevel_priority_select;
    logic       class_change_only;
    logic       detect_change_only;
    logic [1:0] spare10;
  } pgc_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       slave_addr_lsb;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } pgc_access_t;

  typedef struct packed {
    logic [`PGC_NUM_CH-1:0]                done;
    logic [`PGC_NUM_CH*`PGC_RES_W-1:0]     result;
  } pgc_result_t;
endpackage

// ==== dv/pgc_host_model.sv ====
// Host side model: issues register accesses and owns the fast shutdown input.
// Assumes the bench calls its tasks from one process, on core_clk.
`timescale 1ns/1ns
`include "pgc_cfg.svh"
module pgc_host_model (
  core_clk,
  acc,
  fast_shutdown_input
);
  input  wire logic           core_clk;
  output pgc_pkg::pgc_access_t acc;
  output logic                fast_shutdown_input;

  initial begin
    acc = '0;
    fast_shutdown_input = 1'b0;
  end

  // One-cycle strobe, held to the sampling edge, then released
  task automatic access(input logic wr, input logic lsb, input logic [7:0] d);
    @(posedge core_clk);
    acc <= {wr, ~wr, lsb, `PGC_CMD_CONFIG, d};
    @(posedge core_clk);
    acc <= '0;
  endtask

  // Long idle first, so the shutdown bit stream cannot lose sync
  task automatic set_prio(input logic [7:0] d);
    fast_shutdown_input <= 1'b0;
    repeat (`PGC_IDLE_CYCLES) @(posedge core_clk);
    access(1'b1, 1'b0, d);
  endtask
endmodule

// ==== dv/pse_global_irq_access_config_tb.sv ====
// Bench for the global configuration register block.
// Assumes one 100 MHz clock and the host model as register master.
`timescale 1ns/1ns
`include "pgc_cfg.svh"
module pse_global_irq_access_config_tb;
  logic                 core_clk = 1'b0;
  logic                 arst_n = 1'b0;
  pgc_pkg::pgc_access_t acc;
  pgc_pkg::pgc_result_t cls_in = '0;
  pgc_pkg::pgc_result_t det_in = '0;
  logic [15:0]          irq_pending = '0;
  logic [15:0]          irq_mask = '0;
  logic [7:0]           rdata, prio_reg_sel, class_event_flag, detect_event_flag;
  logic                 addr_match, wide_mode, irq_n, prio_3bit, fsi;
  logic [7:0]           rq[$];
  logic [15:0]          fq[$];
  logic                 rd_d = 1'b0;
  logic                 dn_d = 1'b0;
  logic [31:0]          r, pc = '0, pd = '0;
  int                   n_fail = 0;
  int                   tests_run = 0;

  always #5 core_clk = ~core_clk;

  pgc_config u_pgc_config (.core_clk(core_clk), .arst_n(arst_n), .acc(acc), .rdata(rdata),
    .addr_match(addr_match), .wide_mode(wide_mode), .irq_pending(irq_pending),
    .irq_mask(irq_mask), .irq_n(irq_n), .prio_3bit(prio_3bit), .prio_reg_sel(prio_reg_sel),
    .cls_in(cls_in), .det_in(det_in), .class_event_flag(class_event_flag),
    .detect_event_flag(detect_event_flag));
  pgc_host_model u_pgc_host_model (.core_clk(core_clk), .acc(acc), .fast_shutdown_input(fsi));

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic lsb, input logic [7:0] d);
    u_pgc_host_model.access(1'b1, lsb, d);
  endtask

  task automatic rd(input logic lsb, input logic [7:0] exp);
    rq.push_back(exp);
    u_pgc_host_model.access(1'b0, lsb, 8'h00);
  endtask

  // Second pass repeats the same results, so change-only modes must stay quiet
  task automatic events(input logic [7:0] cfg);
    logic [7:0] ec, ed;
    wr(1'b0, cfg);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) r = $urandom;
      for (int c = 0; c < 8; c++) begin
        ec[c] = !cfg[3] || (r[4*c+:4] != pc[4*c+:4]);
        ed[c] = !cfg[2] || (~r[4*c+:4] != pd[4*c+:4]);
      end
      fq.push_back({ec, ed});
      @(posedge core_clk);
      cls_in <= {8'hFF, r};
      det_in <= {8'hFF, ~r};
      pc = r;
      pd = ~r;
      @(posedge core_clk);
      cls_in.done <= 8'h00;
      det_in.done <= 8'h00;
    end
  endtask

  always @(posedge core_clk) begin
    rd_d <= acc.rd;
    dn_d <= |cls_in.done;
  end

  always @(negedge core_clk) begin
    if (rd_d) check("rdata", rdata, rq.pop_front());
    if (dn_d) check("flags", {class_event_flag, detect_event_flag}, fq.pop_front());
  end

  initial begin
    void'($urandom(70));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(1'b0, 8'h80);
    rd(1'b1, 8'h80);
    wr(1'b0, 8'h43);
    rd(1'b0, 8'h43);
    @(posedge core_clk);
    irq_pending <= 16'($urandom) | 16'h0001;
    @(negedge core_clk) check("irq_n", irq_n, 1'b1);
    wr(1'b0, 8'hC3);
    @(negedge core_clk) check("irq_n", irq_n, 1'b0);
    @(posedge core_clk);
    irq_mask <= 16'hFFFF;
    @(negedge core_clk) check("irq_n", irq_n, 1'b1);
    wr(1'b0, 8'h20);
    @(negedge core_clk) check("wide", wide_mode, 1'b1);
    wr(1'b1, 8'hFF);
    rd(1'b0, 8'h20);
    wr(1'b0, 8'h00);
    // The wide write above reached both halves
    rd(1'b1, 8'h00);
    u_pgc_host_model.set_prio(8'h10);
    @(negedge core_clk) check("prio", {prio_3bit, prio_reg_sel}, {1'b1, 8'h27});
    wr(1'b0, 8'h00);
    @(negedge core_clk) check("prio", {prio_3bit, prio_reg_sel}, {1'b0, 8'h15});
    for (int k = 0; k < 4; k++) events({k[0], 3'b000, k[1], k[0], 2'b00});
    repeat (3) @(posedge core_clk);
    complete_run;
  end

  initial begin
    #(40000 * 10);
    n_fail++;
    complete_run;
  end
endmodule
